// ---- core/bidir_printer_port.sv ----
// Bidirectional printer port: host register access over a 2-bit address
// with level read and write strobes, and the parallel pin side.
// Assumes strobes and pins are synchronous to clk; open-drain and tristate
// pins are split into in, out and enable, resolved outside.
//
// Overview of operation
// - Two address bits select data, status, control.
// - Output writes drive pins; input reads sample pins.
// - After reset data pins output, driven high.
// - Status read clears interrupt, sets status bit.
// - Acknowledge falling edge marks interrupt pending.
// - Status bits one and zero read one.
// - Status bits three to six show live inputs.
// - Status bit seven shows busy inverted.
// - Readback register reports actual control pin levels.
// - Readback bit four enable; top three read one.
// - Control write sets the four control lines.
// - Control bit four gates the interrupt output.
// - Direction pin high: control bit five chooses.
// - Direction pin low: codes aa/55 choose direction.
// - Basic variant: direction pin alone sets direction.
// - Reset sets control lines idle, output mode.
// - Style pin low: interrupt follows acknowledge level.
`timescale 1ns/1ns
module bidir_printer_port #(
   parameter bit ENHANCED = 1'b1              // Enhanced variant present
) (
   input  wire logic                      clk,              // 100 MHz clock
   input  wire logic                      rst,              // Async reset
   input  wire logic [1:0]                host_addr,        // Register code
   input  wire logic                      host_wr_n,        // Write strobe
   input  wire logic                      host_rd_n,        // Read strobe
   input  wire logic                      host_sel_n,       // Port select
   input  wire logic [7:0]                host_wdata,       // Write data
   output logic      [7:0]                host_rdata,       // Read data
   input  wire logic                      direction_pin,    // Direction strap
   input  wire logic                      irq_style_sel_n,  // Interrupt style
   input  wire logic [7:0]                par_data_in,      // Pin levels
   output logic      [7:0]                par_data_out,     // Pin drive
   output logic                           par_data_oe,      // Pin enable
   input  wire prn_port_pkg::ctl_lines_t  ctl_in,           // Line levels
   output logic      [3:0]                ctl_out,          // Line drive
   output logic      [3:0]                ctl_oe,           // Line enables
   input  wire prn_port_pkg::status_in_t  stat_in,          // Printer status
   output logic                           printer_irq       // Interrupt
);

   // ************************************************************
   // Declarations
   // ************************************************************
   logic [7:0] data_reg;        // Latched output data
   logic [5:0] ctrl_reg;        // Control bits 5..0
   logic       sw_dir_reg;      // Direction from code writes, 1 = input
   logic       irq_free_reg;    // Status bit 2, 1 = none pending
   logic       ack_prev_reg;    // Previous acknowledge level
   logic       rd_prev_reg;     // Previous read strobe activity
   logic       wr_prev_reg;     // Previous write strobe activity
   logic       input_mode;      // Effective direction, 1 = input
   logic       wr_now;          // Write strobe active
   logic       rd_now;          // Read strobe active
   logic       wr_pulse;        // First cycle of a write
   logic       rd_end;          // First cycle after a read, strobe released
   logic [1:0] rd_addr_reg;     // Address held during read
   logic       ack_fall;        // Falling acknowledge edge
   logic [7:0] status_val;      // Assembled status byte
   logic [7:0] readback_val;    // Assembled readback byte

   // Open-drain line drive: low when asserted, else released high
   function automatic logic od_low(input logic assert_bit);
      od_low = ~assert_bit;
   endfunction : od_low

   // ************************************************************
   // Strobe decode
   // ************************************************************
   // Strobes are levels; act once on the write edge, clear on read end
   assign wr_now   = ~host_wr_n & ~host_sel_n;
   assign rd_now   = ~host_rd_n & ~host_sel_n;
   assign wr_pulse = wr_now & ~wr_prev_reg;
   assign rd_end   = rd_prev_reg & ~rd_now;
   assign ack_fall = ack_prev_reg & ~stat_in.ack_n;

   // Strobe and acknowledge history
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_prev_reg  <= 1'b0;
         rd_prev_reg  <= 1'b0;
         ack_prev_reg <= 1'b1;
         rd_addr_reg  <= 2'h0;
      end else begin
         wr_prev_reg  <= wr_now;
         rd_prev_reg  <= rd_now;
         ack_prev_reg <= stat_in.ack_n;
         // Remember which register is being read
         if (rd_now) begin
            rd_addr_reg <= host_addr;
         end
      end
   end

   // ************************************************************
   // Write side
   // ************************************************************
   // Data latch; reset drives pins high
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         data_reg <= prn_port_pkg::DATA_RESET;
      end else if (wr_pulse && host_addr == prn_port_pkg::ADDR_DATA) begin
         data_reg <= host_wdata;
      end
   end

   // Control register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= prn_port_pkg::CTRL_RESET;
      end else if (wr_pulse && host_addr == prn_port_pkg::ADDR_CTRL) begin
         ctrl_reg <= host_wdata[5:0];
      end
   end

   // Direction select codes; other values leave direction unchanged
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sw_dir_reg <= prn_port_pkg::DIR_RESET;
      end else if (wr_pulse && host_addr == prn_port_pkg::ADDR_STATUS) begin
         if (host_wdata == prn_port_pkg::DIR_CODE_IN) begin
            sw_dir_reg <= 1'b1;
         end else if (host_wdata == prn_port_pkg::DIR_CODE_OUT) begin
            sw_dir_reg <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Direction choice
   // ************************************************************
   always_comb begin
      if (!ENHANCED) begin
         input_mode = direction_pin;
      end else if (direction_pin) begin
         input_mode = ctrl_reg[prn_port_pkg::CTL_DIR];
      end else begin
         input_mode = sw_dir_reg;
      end
   end

   // ************************************************************
   // Pin drive
   // ************************************************************
   assign par_data_out = data_reg;
   assign par_data_oe  = ~input_mode;
   // Lines are open-drain: enable only when pulling low
   assign ctl_out = 4'h0;
   always_comb begin
      ctl_oe[0] = ~od_low(ctrl_reg[prn_port_pkg::CTL_LATCH]);
      ctl_oe[1] = ~od_low(ctrl_reg[prn_port_pkg::CTL_FEED]);
      ctl_oe[2] = od_low(ctrl_reg[prn_port_pkg::CTL_RESTART]);
      ctl_oe[3] = ~od_low(ctrl_reg[prn_port_pkg::CTL_CHOOSE]);
   end

   // ************************************************************
   // Interrupt
   // ************************************************************
   // Pending flag; acknowledge edge wins over a clearing read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_free_reg <= 1'b1;
      end else if (ack_fall) begin
         irq_free_reg <= 1'b0;
      end else if (rd_end && rd_addr_reg == prn_port_pkg::ADDR_STATUS) begin
         irq_free_reg <= 1'b1;
      end
   end

   // Output style, both gated by enable: direct follow or latched
   always_comb begin
      if (!ctrl_reg[prn_port_pkg::CTL_IRQ_EN]) begin
         printer_irq = 1'b0;
      end else if (!irq_style_sel_n) begin
         printer_irq = ~stat_in.ack_n;
      end else begin
         printer_irq = ~irq_free_reg;
      end
   end

   // ************************************************************
   // Read side
   // ************************************************************
   always_comb begin
      status_val = {~stat_in.busy,
                    stat_in.ack_n, stat_in.paper_out,
                    stat_in.printer_online, stat_in.fault_n,
                    irq_free_reg, 2'b11};
      readback_val = {3'b111,
                      ctrl_reg[prn_port_pkg::CTL_IRQ_EN],
                      ~ctl_in.printer_choose_n,
                      ctl_in.restart,
                      ~ctl_in.auto_feed_n,
                      ~ctl_in.latch_pulse_n};
   end

   // Registered read data, loaded while the strobe is low
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         host_rdata <= 8'h00;
      end else if (rd_now) begin
         unique case (host_addr)
            prn_port_pkg::ADDR_DATA:   host_rdata <= input_mode ? par_data_in
                                                                : data_reg;
            prn_port_pkg::ADDR_STATUS: host_rdata <= status_val;
            prn_port_pkg::ADDR_CTRL:   host_rdata <= readback_val;
            default:                   host_rdata <= 8'hff;
         endcase
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   sequence ack_edge_s;
      $fell(stat_in.ack_n);
   endsequence

   chk_ack_sets_pend: assert property (@(posedge clk) disable iff (rst)
      ack_edge_s |=> !irq_free_reg)
      else $error("acknowledge edge did not mark pending");
   chk_read_clears: assert property (@(posedge clk) disable iff (rst)
      (rd_end && rd_addr_reg == prn_port_pkg::ADDR_STATUS && !ack_fall) |=> irq_free_reg)
      else $error("status read did not clear pending");
   chk_irq_gate: assert property (@(posedge clk) disable iff (rst)
      !ctrl_reg[prn_port_pkg::CTL_IRQ_EN] |-> !printer_irq)
      else $error("interrupt not gated by enable");
   chk_irq_follow: assert property (@(posedge clk) disable iff (rst)
      (ctrl_reg[prn_port_pkg::CTL_IRQ_EN] && !irq_style_sel_n) |-> printer_irq == !stat_in.ack_n)
      else $error("interrupt not following acknowledge");
   chk_irq_latched: assert property (@(posedge clk) disable iff (rst)
      (irq_style_sel_n && printer_irq) |-> !irq_free_reg)
      else $error("latched interrupt without pending");
   chk_data_write: assert property (@(posedge clk) disable iff (rst)
      (wr_pulse && host_addr == prn_port_pkg::ADDR_DATA) |=> par_data_out == $past(host_wdata))
      else $error("data write not driven");
   chk_code_in: assert property (@(posedge clk) disable iff (rst)
      (ENHANCED && !direction_pin && wr_pulse && host_addr == prn_port_pkg::ADDR_STATUS
       && host_wdata == prn_port_pkg::DIR_CODE_IN && !$changed(direction_pin)) ##1 !direction_pin
      |-> !par_data_oe)
      else $error("input code did not release pins");
   chk_status_const: assert property (@(posedge clk) disable iff (rst)
      (rd_now && host_addr == prn_port_pkg::ADDR_STATUS) |=> host_rdata[1:0] == 2'b11)
      else $error("status low bits not one");
   chk_ctrl_write: assert property (@(posedge clk) disable iff (rst)
      (wr_pulse && host_addr == prn_port_pkg::ADDR_CTRL && host_wdata[0]) |=> ctl_oe[0])
      else $error("latch line not pulled low");

   // ************************************************************
   // Read path checks
   // ************************************************************
   // Read strobe seen on the status code
   sequence status_read_s;
      rd_now && host_addr == prn_port_pkg::ADDR_STATUS;
   endsequence

   // Read strobe seen on the readback code
   sequence ctrl_read_s;
      rd_now && host_addr == prn_port_pkg::ADDR_CTRL;
   endsequence

   // Read strobe seen on the data code while pins are inputs
   sequence data_in_read_s;
      rd_now && host_addr == prn_port_pkg::ADDR_DATA && input_mode;
   endsequence

   // Busy is reported inverted in the top status bit
   chk_status_busy: assert property (@(posedge clk) disable iff (rst)
      status_read_s |=> host_rdata[7] == !$past(stat_in.busy))
      else $error("status busy bit not inverted");

   // Acknowledge, paper, online and fault levels are live
   chk_status_live: assert property (@(posedge clk) disable iff (rst)
      status_read_s |=> host_rdata[6:3] == $past({stat_in.ack_n, stat_in.paper_out,
                                                 stat_in.printer_online, stat_in.fault_n}))
      else $error("status live bits wrong");

   // Pending flag is reported in the status byte
   chk_status_pend: assert property (@(posedge clk) disable iff (rst)
      status_read_s |=> host_rdata[prn_port_pkg::ST_IRQ] == $past(irq_free_reg))
      else $error("status pending bit wrong");

   // Top three readback bits are fixed at one
   chk_readback_top: assert property (@(posedge clk) disable iff (rst)
      ctrl_read_s |=> host_rdata[7:5] == 3'b111)
      else $error("readback top bits not one");

   // Readback shows the interrupt enable setting
   chk_readback_en: assert property (@(posedge clk) disable iff (rst)
      ctrl_read_s |=> host_rdata[4] == $past(ctrl_reg[prn_port_pkg::CTL_IRQ_EN]))
      else $error("readback enable bit wrong");

   // Readback shows the resolved line levels, not the latch
   chk_readback_pins: assert property (@(posedge clk) disable iff (rst)
      ctrl_read_s |=> host_rdata[3:0] == $past({~ctl_in.printer_choose_n, ctl_in.restart,
                                                ~ctl_in.auto_feed_n, ~ctl_in.latch_pulse_n}))
      else $error("readback line bits wrong");

   // Input mode data reads return the pin levels
   chk_data_in: assert property (@(posedge clk) disable iff (rst)
      data_in_read_s |=> host_rdata == $past(par_data_in))
      else $error("data read did not sample pins");

   // ************************************************************
   // Direction and reset checks
   // ************************************************************
   // Basic variant follows the strap alone
   chk_basic_dir: assert property (@(posedge clk) disable iff (rst)
      !ENHANCED |-> input_mode == direction_pin)
      else $error("basic direction not from strap");

   // Strap high hands direction to control bit five
   chk_soft_dir: assert property (@(posedge clk) disable iff (rst)
      (ENHANCED && direction_pin) |-> input_mode == ctrl_reg[prn_port_pkg::CTL_DIR])
      else $error("control bit five ignored");

   // Output code write while the strap stays low
   sequence code_out_s;
      ENHANCED && !direction_pin && wr_pulse && host_addr == prn_port_pkg::ADDR_STATUS
      && host_wdata == prn_port_pkg::DIR_CODE_OUT;
   endsequence

   // Output code turns the pin drivers back on
   chk_code_out: assert property (@(posedge clk) disable iff (rst)
      code_out_s ##1 !direction_pin |-> par_data_oe)
      else $error("output code did not drive pins");

   // First edge after release still shows the reset state
   chk_reset_state: assert property (@(posedge clk) disable iff (rst)
      $fell(rst) |-> (par_data_oe && par_data_out == prn_port_pkg::DATA_RESET
                      && ctl_oe == 4'h4 && !printer_irq))
      else $error("reset state not held");

endmodule : bidir_printer_port

// ---- core/prn_port_pkg.sv ----
// Package for the bidirectional printer port: register codes, bit positions,
// reset values and carrier structs.
// Assumes a single 100 MHz clock and a host that uses level strobes.
package prn_port_pkg;

   // ************************************************************
   // Register address codes
   // ************************************************************
   localparam logic [1:0] ADDR_DATA   = 2'h0;  // Data port, read and write
   localparam logic [1:0] ADDR_STATUS = 2'h1;  // Status read, direction write
   localparam logic [1:0] ADDR_CTRL   = 2'h2;  // Readback read, control write

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int CTL_LATCH   = 0;  // Latch pulse line
   localparam int CTL_FEED    = 1;  // Auto feed line
   localparam int CTL_RESTART = 2;  // Restart line, active high
   localparam int CTL_CHOOSE  = 3;  // Printer choose line
   localparam int CTL_IRQ_EN  = 4;  // Interrupt enable
   localparam int CTL_DIR     = 5;  // Software direction select
   localparam int ST_IRQ      = 2;  // Status interrupt bit

   // ************************************************************
   // Magic codes and reset values
   // ************************************************************
   localparam logic [7:0] DIR_CODE_IN  = 8'haa;  // Select input direction
   localparam logic [7:0] DIR_CODE_OUT = 8'h55;  // Select output direction
   localparam logic [7:0] DATA_RESET   = 8'hff;  // Data pins driven high
   localparam logic [5:0] CTRL_RESET   = 6'h00;  // Lines idle, irq off, output
   localparam logic       DIR_RESET    = 1'b0;   // Output direction

   // ************************************************************
   // Carriers
   // ************************************************************
   // Printer status inputs
   typedef struct packed {
      logic busy;         // Printer cannot accept data
      logic ack_n;        // Acknowledge, active low
      logic paper_out;    // Out of paper
      logic printer_online; // Printer selected
      logic fault_n;      // Fault, active low
   } status_in_t;

   // Four open-drain control lines, one bit per line
   typedef struct packed {
      logic printer_choose_n; // Choose line
      logic restart;          // Restart line
      logic auto_feed_n;      // Auto feed line
      logic latch_pulse_n;    // Latch pulse line
   } ctl_lines_t;

endpackage : prn_port_pkg

// ---- test/printer_model.sv ----
// Behavioural printer on the far side of the port: bus, lines and status.
// Assumes the design package is compiled first and lines have pull-ups.
`timescale 1ns/1ns
module printer_model (
   input  wire logic                     clk,          // Port clock
   input  wire logic [7:0]               par_data_out, // Port data drive
   input  wire logic                     par_data_oe,  // Port drives bus
   input  wire logic [3:0]               ctl_oe,       // Line pull-downs
   input  wire logic [7:0]               prn_drive,    // Byte printer sends
   input  wire logic [3:0]               prn_flags,    // Busy, paper, online, fault
   input  wire logic                     ack_req,      // Start an ack pulse
   output logic      [7:0]               par_data_in,  // Resolved bus
   output prn_port_pkg::ctl_lines_t      ctl_in,       // Resolved lines
   output prn_port_pkg::status_in_t      stat_in       // Status pins
);
   // ************************************************************
   // Acknowledge pulse and pin resolution
   // ************************************************************
   logic [2:0] ack_cnt;  // Low cycles left on acknowledge
   initial ack_cnt = 3'h0;
   // Acknowledge held low three cycles once asked
   always_ff @(posedge clk) begin
      if (ack_req) begin
         ack_cnt <= 3'h3;
      end else if (ack_cnt != 3'h0) begin
         ack_cnt <= ack_cnt - 3'h1;
      end
   end
   // Printer drives bus only while the port has let go
   assign par_data_in = par_data_oe ? par_data_out : prn_drive;
   // Pull-ups win unless the port pulls low
   assign ctl_in = prn_port_pkg::ctl_lines_t'(~ctl_oe);
   // Busy, paper-out, online and fault levels as commanded; acknowledge from the counter
   assign stat_in = {prn_flags[3], ack_cnt == 3'h0, prn_flags[2:0]};
endmodule : printer_model

// ---- test/bidir_printer_port_bench.sv ----
// Self-checking bench for the printer port: register tasks and pin scenarios.
// Assumes the package, the port and the printer model are compiled first.
`timescale 1ns/1ns
module bidir_printer_port_bench;
   // ************************************************************
   // Signals
   // ************************************************************
   logic       clk, rst, host_wr_n, host_rd_n, direction_pin, irq_style_sel_n;
   logic       ack_req, par_data_oe, printer_irq, basic_oe;
   logic [1:0] host_addr;
   logic [7:0] host_wdata, host_rdata, par_data_in, par_data_out, prn_drive, rd;
   logic [3:0] ctl_out, ctl_oe, prn_flags;
   prn_port_pkg::ctl_lines_t ctl_in;  // Resolved lines
   prn_port_pkg::status_in_t stat_in; // Status pins
   int         n_mismatch, cmp_count;

   // ************************************************************
   // Instances
   // ************************************************************
   bidir_printer_port bidir_printer_port_inst (.clk, .rst, .host_addr, .host_wr_n,
      .host_rd_n, .host_sel_n(1'b0), .host_wdata, .host_rdata, .direction_pin,
      .irq_style_sel_n, .par_data_in, .par_data_out, .par_data_oe, .ctl_in, .ctl_out,
      .ctl_oe, .stat_in, .printer_irq);
   // Basic variant watched for its direction only
   bidir_printer_port #(.ENHANCED(1'b0)) bidir_printer_port_basic_inst (.clk, .rst,
      .host_addr, .host_wr_n, .host_rd_n, .host_sel_n(1'b0), .host_wdata,
      .host_rdata(), .direction_pin, .irq_style_sel_n, .par_data_in, .par_data_out(),
      .par_data_oe(basic_oe), .ctl_in, .ctl_out(), .ctl_oe(), .stat_in, .printer_irq());
   printer_model printer_model_inst (.clk, .par_data_out, .par_data_oe, .ctl_oe,
      .prn_drive, .prn_flags, .ack_req, .par_data_in, .ctl_in, .stat_in);

   // ************************************************************
   // Shared tasks
   // ************************************************************
   // Byte compare
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   // Register write, strobe high one cycle after
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      host_addr <= a;
      host_wdata <= d;
      host_wr_n <= 1'b0;
      @(posedge clk);
      host_wr_n <= 1'b1;
      @(posedge clk);
      #1;
   endtask : wr
   // Register read, data taken after the sampling edge
   task automatic rd_reg(input logic [1:0] a);
      @(posedge clk);
      host_addr <= a;
      host_rd_n <= 1'b0;
      @(posedge clk);
      host_rd_n <= 1'b1;
      #1 rd = host_rdata;
   endtask : rd_reg
   // One acknowledge pulse, then settle
   task automatic ack_pulse;
      @(posedge clk) ack_req <= 1'b1;
      @(posedge clk) ack_req <= 1'b0;
      repeat (5) @(posedge clk);
      #1;
   endtask : ack_pulse
   // Counts and verdict
   task automatic end_sim;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_sim

   // ************************************************************
   // Scenarios
   // ************************************************************
   // Reset state of pins and readback
   task automatic t_reset;
      cmp(par_data_out, 8'hff);
      cmp({7'h0, par_data_oe}, 8'h01);
      cmp({4'h0, ctl_oe}, 8'h04);
      cmp({4'h0, ctl_out}, 8'h00);
      rd_reg(2'h2);
      cmp(rd, 8'he0);
   endtask : t_reset
   // Control lines driven and read back, data port, unmapped code
   task automatic t_ctrl_data;
      wr(2'h2, 8'h0f);
      cmp({4'h0, ctl_oe}, 8'h0b);
      rd_reg(2'h2);
      cmp(rd, 8'hef);
      wr(2'h2, 8'h10);
      rd_reg(2'h2);
      cmp(rd, 8'hf0);
      wr(2'h0, 8'ha5);
      cmp(par_data_out, 8'ha5);
      wr(2'h3, 8'h00);
      rd_reg(2'h3);
      cmp(rd, 8'hff);
      cmp(par_data_out, 8'ha5);
   endtask : t_ctrl_data
   // Every status flag combination
   task automatic t_status;
      for (int i = 0; i < 16; i++) begin
         @(posedge clk) prn_flags <= 4'(i);
         rd_reg(2'h1);
         cmp(rd, {~prn_flags[3], 1'b1, prn_flags[2:0], 3'h7});
      end
   endtask : t_status
   // Direction by control bit, by code, and on the basic variant
   task automatic t_dir;
      @(posedge clk) direction_pin <= 1'b1;
      wr(2'h2, 8'h20);
      cmp({7'h0, par_data_oe}, 8'h00);
      cmp({7'h0, basic_oe}, 8'h00);
      rd_reg(2'h0);
      cmp(rd, 8'h3c);
      wr(2'h2, 8'h10);
      cmp({7'h0, par_data_oe}, 8'h01);
      @(posedge clk) direction_pin <= 1'b0;
      wr(2'h1, 8'haa);
      cmp({7'h0, par_data_oe}, 8'h00);
      wr(2'h1, 8'h33);
      cmp({7'h0, par_data_oe}, 8'h00);
      wr(2'h1, 8'h55);
      cmp({7'h0, par_data_oe}, 8'h01);
      cmp({7'h0, basic_oe}, 8'h01);
   endtask : t_dir
   // Latched, masked and direct interrupt
   task automatic t_irq;
      @(posedge clk) irq_style_sel_n <= 1'b1;
      ack_pulse;
      cmp({7'h0, printer_irq}, 8'h01);
      rd_reg(2'h1);
      cmp({7'h0, rd[2]}, 8'h00);
      @(posedge clk) #1;
      cmp({7'h0, printer_irq}, 8'h00);
      rd_reg(2'h1);
      cmp({7'h0, rd[2]}, 8'h01);
      wr(2'h2, 8'h00);
      ack_pulse;
      cmp({7'h0, printer_irq}, 8'h00);
      wr(2'h2, 8'h10);
      cmp({7'h0, printer_irq}, 8'h01);
      rd_reg(2'h1);
      @(posedge clk) irq_style_sel_n <= 1'b0;
      @(posedge clk) ack_req <= 1'b1;
      @(posedge clk) ack_req <= 1'b0;
      @(posedge clk) #1 cmp({7'h0, printer_irq}, 8'h01);
      repeat (5) @(posedge clk);
      #1 cmp({7'h0, printer_irq}, 8'h00);
   endtask : t_irq

   // ************************************************************
   // Clock, sequence and watchdog
   // ************************************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      {rst, host_wr_n, host_rd_n} = 3'h7;
      {direction_pin, irq_style_sel_n, ack_req} = 3'h0;
      host_addr = 2'h0;
      host_wdata = 8'h00;
      prn_drive = 8'h3c;
      prn_flags = 4'h0;
      n_mismatch = 0;
      cmp_count = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk) #1;
      t_reset;
      t_ctrl_data;
      t_status;
      t_dir;
      t_irq;
      end_sim;
   end
   // Cut a hang short
   initial begin
      #200000;
      n_mismatch++;
      end_sim;
   end
endmodule : bidir_printer_port_bench
